// ---- verilog/aac_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module aac_top
   import aac_pkg::*;
#(
   parameter int RAMP_CYCLES = REF_RAMP_CYC
) (
   input  wire logic                            core_clk,
   input  wire logic                            srst,
   input  wire logic                            regWrEn,
   input  wire logic                            regRdEn,
   input  wire logic [7:0]                      regAddr,
   input  wire logic [7:0]                      regWrData,
   output var  logic [7:0]                      regRdData,
   input  wire logic                            frameClkIn,
   input  wire logic                            bitClkIn,
   output var  logic                            frameClkOut,
   output var  logic                            frameClkOe,
   output var  logic                            bitClkOut,
   output var  logic                            bitClkOe,
   output var  logic                            modClk,
   input  wire logic                            decValid,
   input  wire logic [NUM_CH-1:0][SAMPLE_W-1:0] decIn,
   output var  logic [NUM_CH-1:0][SAMPLE_W-1:0] sampleOut,
   output var  logic                            sampleValid,
   output var  logic                            serialMute,
   output var  logic                            lowPower,
   output var  logic [2:0]                      inputMux,
   output var  logic                            micGainEn,
   output var  logic                            auxOutEn,
   output var  logic [7:0]                      gainAOut,
   output var  logic [7:0]                      gainBOut
);
   aac_state_t st_reg;
   aac_state_t st_next;
   logic [NUM_CH-1:0][SAMPLE_W-1:0] offNext;
   logic [NUM_CH-1:0][SAMPLE_W-1:0] outNext;
   logic [10:0] mclkPerFs;
   logic [4:0]  bitPeriod;
   logic        boundary;
   logic        masterTick;

   // clamp a written gain code into the supported span
   function automatic logic [7:0] clampGain(input logic [7:0] g);
      logic signed [7:0] s;
      s = $signed(g);
      if (s > GAIN_MAX) begin
         clampGain = GAIN_MAX;
      end else if (s < GAIN_MIN) begin
         clampGain = GAIN_MIN;
      end else begin
         clampGain = g;
      end
   endfunction

   // per-channel offset tracking and subtraction
   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_hpf
      logic signed [SAMPLE_W:0] diff;
      logic signed [SAMPLE_W:0] step;
      logic signed [SAMPLE_W:0] corr;
      logic                     subtract;
      assign diff = $signed({decIn[ch][SAMPLE_W-1], decIn[ch]})
                  - $signed({st_reg.offset[ch][SAMPLE_W-1], st_reg.offset[ch]});
      assign step = diff >>> HPF_SHIFT;
      // estimate moves a fraction of the error per sample; frozen while held
      assign offNext[ch] = st_reg.hold ? st_reg.offset[ch]
                         : SAMPLE_W'(st_reg.offset[ch] + step[SAMPLE_W-1:0]);
      // a held offset keeps being subtracted even with tracking off
      assign subtract = st_reg.hpfOn | st_reg.hold;
      assign corr = subtract ? diff : $signed({decIn[ch][SAMPLE_W-1], decIn[ch]});
      // saturate instead of wrapping so a large offset cannot flip sign
      assign outNext[ch] = (corr[SAMPLE_W] != corr[SAMPLE_W-1])
                         ? {corr[SAMPLE_W], {(SAMPLE_W-1){~corr[SAMPLE_W]}}}
                         : corr[SAMPLE_W-1:0];
   end

   // divider choice from ratio code and speed mode
   always_comb begin
      case (st_reg.ratio)
         3'h0:    mclkPerFs = RATIO_256;
         3'h1:    mclkPerFs = RATIO_384;
         3'h2:    mclkPerFs = RATIO_512;
         3'h3:    mclkPerFs = RATIO_768;
         3'h4:    mclkPerFs = RATIO_1024;
         default: mclkPerFs = RATIO_256;
      endcase
      case (st_reg.speed)
         SPD_SINGLE: mclkPerFs = mclkPerFs;
         SPD_DOUBLE: mclkPerFs = mclkPerFs >> 1;
         default:    mclkPerFs = mclkPerFs >> 2;
      endcase
      // bit clock is 64 per frame; a flop cannot toggle faster than half rate
      bitPeriod = 5'(mclkPerFs >> BITS_PER_FRAME_LOG2);
      if (bitPeriod < BIT_PERIOD_MIN) begin
         bitPeriod = BIT_PERIOD_MIN;
      end
   end

   // sample boundary: own frame rise as master, sampled input rise as slave
   assign masterTick = (st_reg.divCnt == bitPeriod - 5'h01);
   assign boundary = st_reg.master
                   ? (masterTick && st_reg.bitCnt == HALF_FRAME_LAST && !st_reg.frameClk)
                   : (frameClkIn && !st_reg.frameInPrev);

   // next-state logic for the whole block
   always_comb begin
      st_next = st_reg;
      st_next.frameInPrev = frameClkIn;
      st_next.rdData = 8'h00;
      st_next.sampValid = 1'b0;
      // register writes; power-down and config accepted in any state
      if (regWrEn) begin
         case (regAddr)
            ADDR_POWER_CTRL: st_next.power_down_bit = regWrData[POS_PDN];
            ADDR_FUNC_MODE: begin
               st_next.speed  = regWrData[POS_SPEED_LO+1:POS_SPEED_LO];
               st_next.master = regWrData[POS_MASTER];
               st_next.hold   = regWrData[POS_HOLD];
               st_next.hpfOn  = regWrData[POS_HPF_ON];
            end
            ADDR_INPUT_SEL:  st_next.inSel = regWrData[2:0];
            ADDR_MCLK_RATIO: begin
               st_next.auxSel = regWrData[POS_AUX];
               st_next.ratio  = regWrData[2:0];
            end
            ADDR_GAIN_B:     st_next.gainB = clampGain(regWrData);
            ADDR_GAIN_A:     st_next.gainA = clampGain(regWrData);
            default: ;
         endcase
      end
      // register reads, answered one cycle later; unmapped reads give zero
      if (regRdEn) begin
         case (regAddr)
            ADDR_POWER_CTRL: st_next.rdData = {7'h00, st_reg.power_down_bit};
            ADDR_FUNC_MODE:  st_next.rdData = {st_reg.speed, st_reg.master, 3'h0, st_reg.hold, st_reg.hpfOn};
            ADDR_INPUT_SEL:  st_next.rdData = {5'h00, st_reg.inSel};
            ADDR_MCLK_RATIO: st_next.rdData = {1'b0, st_reg.auxSel, 3'h0, st_reg.ratio};
            ADDR_GAIN_B:     st_next.rdData = st_reg.gainB;
            ADDR_GAIN_A:     st_next.rdData = st_reg.gainA;
            ADDR_STATUS:     st_next.rdData = {6'h00, st_reg.mode};
            default:         st_next.rdData = 8'h00;
         endcase
      end
      // power sequencing
      case (st_reg.mode)
         ST_LOWPOWER: begin
            if (!st_reg.power_down_bit) begin
               st_next.mode = ST_RAMP;
               st_next.rampCnt = 20'h00000;
            end
         end
         ST_RAMP: begin
            st_next.rampCnt = st_reg.rampCnt + 20'h00001;
            if (st_reg.power_down_bit) begin
               st_next.mode = ST_LOWPOWER;
            end else if (st_reg.rampCnt == 20'(RAMP_CYCLES - 1)) begin
               st_next.mode = ST_RUN;
            end
         end
         ST_RUN: begin
            if (st_reg.power_down_bit) begin
               st_next.mode = ST_LOWPOWER;
            end
         end
         default: st_next.mode = ST_LOWPOWER;
      endcase
      st_next.lowPower = (st_next.mode == ST_LOWPOWER);
      st_next.mute = (st_next.mode != ST_RUN);
      // clocks stop with the next state, so no clock flop stays high in the first low-power cycle
      if (st_next.lowPower) begin
         st_next.modClk = 1'b0;
         st_next.divCnt = 5'h00;
         st_next.bitCnt = 5'h00;
         st_next.bitClk = 1'b0;
         st_next.frameClk = 1'b0;
      end else begin
         st_next.modClk = ~st_reg.modClk; // half master clock
         // frame clock toggles every 32 bit clocks: 64 bit clocks per frame
         st_next.divCnt = masterTick ? 5'h00 : st_reg.divCnt + 5'h01;
         st_next.bitClk = (st_next.divCnt < (bitPeriod >> 1));
         if (masterTick) begin
            st_next.bitCnt = st_reg.bitCnt + 5'h01;
            if (st_reg.bitCnt == HALF_FRAME_LAST) begin
               st_next.frameClk = ~st_reg.frameClk;
            end
         end
      end
      // gain codes move to the analog stage only at a frame boundary
      if (boundary) begin
         st_next.appGainA = st_reg.gainA;
         st_next.appGainB = st_reg.gainB;
      end
      // mux routing: mic gain only ever on pair four
      if (st_reg.inSel == SEL_MIC4) begin
         st_next.muxSel = MUX_IN4;
         st_next.micEn = 1'b1;
      end else if (st_reg.inSel <= SEL_LINE6) begin
         st_next.muxSel = st_reg.inSel - 3'h1;
         st_next.micEn = 1'b0;
      end else begin
         st_next.muxSel = MUX_IN1;
         st_next.micEn = 1'b0;
      end
      st_next.auxEn = st_reg.auxSel & ~st_reg.lowPower;
      // decimated samples; zeroed while muted
      if (decValid && !st_reg.lowPower) begin
         st_next.sampValid = 1'b1;
         if (st_reg.hpfOn && !st_reg.hold) begin
            st_next.offset = offNext;
         end
         st_next.sampOut = st_reg.mute ? '0 : outNext;
      end
   end

   // state register; reset returns every default
   always_ff @(posedge core_clk) begin
      if (srst) begin
         st_reg <= '0;
         st_reg.power_down_bit <= 1'b1;
         st_reg.hpfOn <= 1'b1;
         st_reg.inSel <= SEL_LINE1;
         st_reg.gainA <= GAIN_UNITY;
         st_reg.gainB <= GAIN_UNITY;
         st_reg.appGainA <= GAIN_UNITY;
         st_reg.appGainB <= GAIN_UNITY;
         st_reg.muxSel <= MUX_IN1;
         st_reg.mode <= ST_LOWPOWER;
         st_reg.lowPower <= 1'b1;
         st_reg.mute <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state flops
   assign regRdData   = st_reg.rdData;
   assign frameClkOut = st_reg.frameClk;
   assign frameClkOe  = st_reg.master;
   assign bitClkOut   = st_reg.bitClk;
   assign bitClkOe    = st_reg.master;
   assign modClk      = st_reg.modClk;
   assign sampleOut   = st_reg.sampOut;
   assign sampleValid = st_reg.sampValid;
   assign serialMute  = st_reg.mute;
   assign lowPower    = st_reg.lowPower;
   assign inputMux    = st_reg.muxSel;
   assign micGainEn   = st_reg.micEn;
   assign auxOutEn    = st_reg.auxEn;
   assign gainAOut    = st_reg.appGainA;
   assign gainBOut    = st_reg.appGainB;
endmodule
`default_nettype wire

// ---- verilog/aac_pkg.sv ----
package aac_pkg;
   // register offsets
   localparam logic [7:0] ADDR_POWER_CTRL  = 8'h02;
   localparam logic [7:0] ADDR_FUNC_MODE   = 8'h03;
   localparam logic [7:0] ADDR_INPUT_SEL   = 8'h04;
   localparam logic [7:0] ADDR_MCLK_RATIO  = 8'h05;
   localparam logic [7:0] ADDR_GAIN_B      = 8'h07;
   localparam logic [7:0] ADDR_GAIN_A      = 8'h08;
   localparam logic [7:0] ADDR_STATUS      = 8'h09;
   // field positions
   localparam int POS_PDN      = 0;
   localparam int POS_HPF_ON   = 0;
   localparam int POS_HOLD     = 1;
   localparam int POS_MASTER   = 5;
   localparam int POS_SPEED_LO = 6;
   localparam int POS_AUX      = 6;
   // input select codes
   localparam logic [2:0] SEL_MIC4  = 3'h0;
   localparam logic [2:0] SEL_LINE1 = 3'h1;
   localparam logic [2:0] SEL_LINE4 = 3'h4;
   localparam logic [2:0] SEL_LINE6 = 3'h6;
   localparam logic [2:0] MUX_IN1   = 3'h0;
   localparam logic [2:0] MUX_IN4   = 3'h3;
   // gain limits in half-dB steps
   localparam logic signed [7:0] GAIN_MAX  = 8'sh18;
   localparam logic signed [7:0] GAIN_MIN  = -8'sh18;
   localparam logic [7:0]        GAIN_UNITY = 8'h00;
   // speed modes
   localparam logic [1:0] SPD_SINGLE = 2'h0;
   localparam logic [1:0] SPD_DOUBLE = 2'h1;
   localparam logic [1:0] SPD_QUAD   = 2'h2;
   // master clock per frame, single speed, by ratio code
   localparam logic [10:0] RATIO_256  = 11'h100;
   localparam logic [10:0] RATIO_384  = 11'h180;
   localparam logic [10:0] RATIO_512  = 11'h200;
   localparam logic [10:0] RATIO_768  = 11'h300;
   localparam logic [10:0] RATIO_1024 = 11'h400;
   localparam int BITS_PER_FRAME_LOG2 = 6;
   localparam logic [4:0] BIT_PERIOD_MIN = 5'h02;
   localparam logic [4:0] HALF_FRAME_LAST = 5'h1F;
   // timing
   localparam int CLK_MHZ       = 40;
   localparam int REF_RAMP_US   = 1000;
   localparam int REF_RAMP_CYC  = REF_RAMP_US * CLK_MHZ;
   localparam int SAMPLE_W      = 24;
   localparam int HPF_SHIFT     = 10;
   localparam int NUM_CH        = 2;

   typedef enum logic [1:0] {ST_LOWPOWER, ST_RAMP, ST_RUN} aac_mode_t;

   typedef struct packed {
      logic                                power_down_bit;
      logic [1:0]                          speed;
      logic                                master;
      logic                                hold;
      logic                                hpfOn;
      logic [2:0]                          inSel;
      logic                                auxSel;
      logic [2:0]                          ratio;
      logic [7:0]                          gainB;
      logic [7:0]                          gainA;
      aac_mode_t                           mode;
      logic                                lowPower;
      logic                                mute;
      logic [19:0]                         rampCnt;
      logic [4:0]                          divCnt;
      logic [4:0]                          bitCnt;
      logic                                bitClk;
      logic                                frameClk;
      logic                                modClk;
      logic                                frameInPrev;
      logic [2:0]                          muxSel;
      logic                                micEn;
      logic                                auxEn;
      logic [7:0]                          appGainA;
      logic [7:0]                          appGainB;
      logic [NUM_CH-1:0][SAMPLE_W-1:0]     offset;
      logic [NUM_CH-1:0][SAMPLE_W-1:0]     sampOut;
      logic                                sampValid;
      logic [7:0]                          rdData;
   } aac_state_t;
endpackage

// ---- test/aac_top_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module aac_top_props
   import aac_pkg::*;
#(
   parameter int RAMP_CYCLES = 8
) (
   input wire logic                            core_clk,
   input wire logic                            srst,
   input wire logic                            regRdEn,
   input wire logic [7:0]                      regRdData,
   input wire logic                            frameClkOut,
   input wire logic                            frameClkOe,
   input wire logic                            bitClkOut,
   input wire logic                            bitClkOe,
   input wire logic                            modClk,
   input wire logic                            decValid,
   input wire logic [NUM_CH-1:0][SAMPLE_W-1:0] sampleOut,
   input wire logic                            sampleValid,
   input wire logic                            serialMute,
   input wire logic                            lowPower,
   input wire logic [2:0]                      inputMux,
   input wire logic                            micGainEn,
   input wire logic [7:0]                      gainAOut,
   input wire logic [7:0]                      gainBOut
);
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (srst);
   // checks on state, clocks, samples and gain timing
   rst_state_a: assert property ($fell(srst) |-> lowPower && serialMute && !sampleValid)
      else $error("outputs not quiet after reset");
   rd_idle_a: assert property (!regRdEn |=> regRdData == 8'h00)
      else $error("read data without a read");
   smp_lat_a: assert property (sampleValid |-> $past(decValid))
      else $error("sample without decimator pulse");
   mute_zero_a: assert property (sampleValid && serialMute |-> sampleOut == '0)
      else $error("muted sample not zero");
   ramp_mute_a: assert property ($fell(lowPower) |-> serialMute [*4])
      else $error("mute dropped early in ramp");
   lp_clk_a: assert property (lowPower |-> !frameClkOut && !bitClkOut && !modClk)
      else $error("clocks running in low power");
   mod_half_a: assert property (!lowPower && !$past(lowPower) |-> modClk != $past(modClk))
      else $error("modulator clock not half rate");
   oe_pair_a: assert property (frameClkOe == bitClkOe)
      else $error("clock enables differ");
   mux_range_a: assert property (inputMux <= 3'h5)
      else $error("input pair out of range");
   mic_pair_a: assert property (micGainEn |-> inputMux == MUX_IN4)
      else $error("mic gain off pair four");
   gain_lim_a: assert property ($signed(gainAOut) <= GAIN_MAX && $signed(gainAOut) >= GAIN_MIN
                                && $signed(gainBOut) <= GAIN_MAX && $signed(gainBOut) >= GAIN_MIN)
      else $error("gain beyond limit");
   // applied gain and own frame clock are loaded by the same edge
   gain_step_a: assert property ($changed(gainAOut) && $past(frameClkOe) |-> $rose(frameClkOut))
      else $error("gain changed off frame boundary");
   cover property (sampleValid && !serialMute);
   cover property ($rose(frameClkOut));
   cover property (micGainEn);
endmodule
`default_nettype wire

// ---- test/aac_far_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module aac_far_model #(
   parameter int FRAME_CYC = 256,
   parameter int BIT_RATIO = 64
) (
   input  wire logic core_clk,
   input  wire logic run,
   output var  logic frameClk,
   output var  logic bitClk
);
   localparam int BIT_CYC = FRAME_CYC / BIT_RATIO;
   int cnt = 0;
   initial begin
      frameClk = 1'b0;
      bitClk   = 1'b0;
   end
   // counted off the master clock so they cannot drift; held low between runs
   always @(posedge core_clk) begin
      cnt      <= run ? (cnt + 1) % FRAME_CYC : 0;
      frameClk <= run && cnt >= FRAME_CYC / 2;
      bitClk   <= run && cnt % BIT_CYC >= BIT_CYC / 2;
   end
endmodule
`default_nettype wire

// ---- test/test_audio_adc_clock_and_config_control.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_audio_adc_clock_and_config_control
   import aac_pkg::*;
;
   localparam int RAMP = 8;
   logic                            core_clk  = 1'b0;
   logic                            srst      = 1'b1;
   logic                            regWrEn   = 1'b0;
   logic                            regRdEn   = 1'b0;
   logic [7:0]                      regAddr   = 8'h00;
   logic [7:0]                      regWrData = 8'h00;
   logic                            decValid  = 1'b0;
   logic                            farRun    = 1'b0;
   logic [NUM_CH-1:0][SAMPLE_W-1:0] decIn     = '0;
   logic [NUM_CH-1:0][SAMPLE_W-1:0] sampleOut;
   logic [7:0]                      regRdData, gainAOut, gainBOut;
   logic [2:0]                      inputMux;
   logic                            frameClkIn, bitClkIn, frameClkOut, frameClkOe, bitClkOut, bitClkOe;
   logic                            modClk, sampleValid, serialMute, lowPower, micGainEn, auxOutEn;
   logic signed [SAMPLE_W-1:0]      offs [NUM_CH] = '{default: '0};
   logic [4:0]                      clkTbl [4] = '{5'h00, 5'h04, 5'h0A, 5'h10};
   logic [7:0]                      gainTbl [4] = '{8'h30, 8'hE8, 8'h80, 8'h18};
   int                              errorCnt = 0;
   int                              nCompared = 0;
   int                              seed = 71973;

   always #12.5 core_clk = ~core_clk;

   aac_top #(.RAMP_CYCLES(RAMP)) dut (
      .core_clk, .srst, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .frameClkIn, .bitClkIn,
      .frameClkOut, .frameClkOe, .bitClkOut, .bitClkOe, .modClk, .decValid, .decIn, .sampleOut,
      .sampleValid, .serialMute, .lowPower, .inputMux, .micGainEn, .auxOutEn, .gainAOut, .gainBOut
   );
   aac_far_model far (.core_clk, .run(farRun), .frameClk(frameClkIn), .bitClk(bitClkIn));

   task automatic finalReport();
      $display("compared %0d, mismatches %0d", nCompared, errorCnt);
      if (errorCnt == 0 && nCompared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic cmp(input logic [NUM_CH*SAMPLE_W-1:0] got, input logic [NUM_CH*SAMPLE_W-1:0] exp);
      nCompared++;
      if (got !== exp) begin
         errorCnt++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // strobes are one cycle wide and change only on the falling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      regWrEn = 1'b1;
      regAddr = a;
      regWrData = d;
      @(negedge core_clk);
      regWrEn = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge core_clk);
      regRdEn = 1'b1;
      regAddr = a;
      @(negedge core_clk);
      regRdEn = 1'b0;
      cmp(regRdData, exp);
   endtask
   function automatic logic pick(input int w);
      return w == 0 ? frameClkOut : w == 1 ? bitClkOut : frameClkIn;
   endfunction
   // cycles to the next rising edge; a stalled clock ends the run
   task automatic rise(input int w, output int n);
      logic prev;
      prev = pick(w);
      for (n = 1; n <= 3000; n++) begin
         @(negedge core_clk);
         if (pick(w) && !prev) return;
         prev = pick(w);
      end
      errorCnt++;
      $display("FAIL t=%0t clock stalled", $time);
      finalReport();
   endtask
   // expectations: {mic gain, pair}, clamped gain, frame length in master clocks
   function automatic logic [3:0] selExp(input logic [2:0] c);
      if (c == 3'h0) return {1'b1, MUX_IN4};
      if (c == 3'h7) return {1'b0, MUX_IN1};
      return {1'b0, c - 3'h1};
   endfunction
   function automatic logic [7:0] clampExp(input logic [7:0] g);
      if ($signed(g) > GAIN_MAX) return GAIN_MAX;
      if ($signed(g) < GAIN_MIN) return GAIN_MIN;
      return g;
   endfunction
   function automatic int frameExp(input logic [1:0] s, input logic [2:0] r);
      int m;
      m = r == 1 ? 384 : r == 2 ? 512 : r == 3 ? 768 : r == 4 ? 1024 : 256;
      m = m >> (s[1] ? 2 : s[0]);
      return (m / 64 < 2 ? 2 : m / 64) * 64;
   endfunction
   // one random pair through the offset filter, checked a cycle later
   task automatic sample(input logic hold, input logic hpf);
      logic [NUM_CH-1:0][SAMPLE_W-1:0] exp;
      logic signed [SAMPLE_W-1:0]      d;
      logic signed [SAMPLE_W-1:0]      e;
      @(negedge core_clk);
      for (int c = 0; c < NUM_CH; c++) begin
         d = SAMPLE_W'($random(seed) >>> 12);
         e = d - offs[c];
         decIn[c] = d;
         exp[c] = (hold || hpf) ? e : d;
         if (hpf && !hold) offs[c] = offs[c] + (e >>> HPF_SHIFT);
      end
      decValid = 1'b1;
      @(negedge core_clk);
      decValid = 1'b0;
      cmp(sampleValid, 1'b1);
      cmp(sampleOut, exp);
   endtask

   initial begin
      int         i;
      int         n;
      logic [7:0] g;
      logic [7:0] oldG;
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
      srst = 1'b0;
      // defaults, then the unmapped hole
      cmp(lowPower, 1'b1);
      cmp(inputMux, MUX_IN1);
      rd(ADDR_POWER_CTRL, 8'h01);
      rd(ADDR_INPUT_SEL, 8'h01);
      rd(ADDR_GAIN_B, GAIN_UNITY);
      rd(ADDR_GAIN_A, GAIN_UNITY);
      wr(8'h0A, 8'hFF);
      rd(8'h0A, 8'h00);
      // every select code, loaded while still powered down
      for (i = 0; i < 8; i++) begin
         wr(ADDR_INPUT_SEL, 8'(i));
         cyc(2);
         cmp({micGainEn, inputMux}, selExp(3'(i)));
      end
      // aux select is held off while powered down
      wr(ADDR_MCLK_RATIO, 8'h40);
      cyc(2);
      cmp(auxOutEn, 1'b0);
      // power up as master, filter off so a ramp sample leaves the offset alone
      wr(ADDR_FUNC_MODE, 8'h20);
      wr(ADDR_POWER_CTRL, 8'h00);
      cyc(1);
      decIn = '1;
      decValid = 1'b1;
      @(negedge core_clk);
      decValid = 1'b0;
      cmp(sampleOut, '0);
      cmp(lowPower, 1'b0);
      for (n = 0; n < 40 && serialMute; n++)
         @(negedge core_clk);
      cmp(n >= RAMP - 5 && n <= RAMP + 3, 1'b1);
      if (n == 40) finalReport();
      rd(ADDR_STATUS, 8'h02);
      // once running the aux pins follow the select bit
      cmp(auxOutEn, 1'b1);
      wr(ADDR_MCLK_RATIO, 8'h00);
      cyc(2);
      cmp(auxOutEn, 1'b0);
      // divider corners; the first frame after a change may be odd
      foreach (clkTbl[k]) begin
         wr(ADDR_FUNC_MODE, {clkTbl[k][4:3], 6'h21});
         wr(ADDR_MCLK_RATIO, {5'h00, clkTbl[k][2:0]});
         repeat (3) rise(0, n);
         cmp(n, frameExp(clkTbl[k][4:3], clkTbl[k][2:0]));
         repeat (3) rise(1, n);
         cmp(n, frameExp(clkTbl[k][4:3], clkTbl[k][2:0]) / 64);
      end
      wr(ADDR_FUNC_MODE, 8'h21);
      // gains land only at the next frame, clamped
      oldG = GAIN_UNITY;
      for (i = 0; i < 5; i++) begin
         g = i < 4 ? gainTbl[i] : 8'($random(seed));
         rise(0, n);
         wr(ADDR_GAIN_A, g);
         wr(ADDR_GAIN_B, ~g);
         cmp(gainAOut, oldG);
         rise(0, n);
         cyc(1);
         cmp(gainAOut, clampExp(g));
         cmp(gainBOut, clampExp(~g));
         rd(ADDR_GAIN_A, clampExp(g));
         oldG = clampExp(g);
      end
      // offset tracking, frozen, calibrated, then plain pass-through
      repeat (6) sample(1'b0, 1'b1);
      wr(ADDR_FUNC_MODE, 8'h23);
      repeat (3) sample(1'b1, 1'b1);
      wr(ADDR_FUNC_MODE, 8'h22);
      repeat (2) sample(1'b1, 1'b0);
      wr(ADDR_FUNC_MODE, 8'h20);
      sample(1'b0, 1'b0);
      // slave: pins released, gain follows the incoming frame clock
      wr(ADDR_FUNC_MODE, 8'h01);
      farRun = 1'b1;
      cyc(2);
      cmp({frameClkOe, bitClkOe}, 2'b00);
      rise(2, n);
      wr(ADDR_GAIN_A, 8'h05);
      rise(2, n);
      cyc(2);
      cmp(gainAOut, 8'h05);
      // reset in mid-run, then power down from run
      srst = 1'b1;
      cyc(2);
      srst = 1'b0;
      cmp(lowPower, 1'b1);
      rd(ADDR_GAIN_A, GAIN_UNITY);
      wr(ADDR_POWER_CTRL, 8'h00);
      cyc(RAMP + 4);
      wr(ADDR_POWER_CTRL, 8'h01);
      cyc(2);
      cmp({lowPower, serialMute, modClk}, 3'b110);
      farRun = 1'b0;
      finalReport();
   end
endmodule

bind aac_top aac_top_props #(.RAMP_CYCLES(RAMP_CYCLES)) props (
   .core_clk, .srst, .regRdEn, .regRdData, .frameClkOut, .frameClkOe, .bitClkOut, .bitClkOe, .modClk,
   .decValid, .sampleOut, .sampleValid, .serialMute, .lowPower, .inputMux, .micGainEn, .gainAOut, .gainBOut
);
`default_nettype wire
